// [hdl/lmrc_defs.svh]
// Purpose: Constants of the LCD matrix RAM and command core
// Assumes: Included by the core and by the testbench
// Notes: Offsets are byte addresses on the register bus
`ifndef LMRC_DEFS_SVH
`define LMRC_DEFS_SVH
// Register offsets
`define LMRC_OFF_CMD 4'h0
`define LMRC_OFF_DATA 4'h4
`define LMRC_OFF_STAT 4'h8
`define LMRC_OFF_CONF 4'hc
// Command pages
`define LMRC_PAGE_FUNC 2'h0
`define LMRC_PAGE_DISP 2'h1
`define LMRC_PAGE_HV 2'h2
// Geometry
`define LMRC_BANKS 6
`define LMRC_COLS 128
`define LMRC_LAST_X 7'h7f
`define LMRC_LAST_Y 3'h4
`define LMRC_ICON_Y 3'h5
`define LMRC_ICON_ROW 6'h21
// Reset values
`define LMRC_RST_PD 1'b1
`define LMRC_RST_V 1'b0
`define LMRC_RST_CODE 8'h00
// Voltage in millivolts
`define LMRC_VOFS_LO 14'h0b7c
`define LMRC_VOFS_HI 14'h1a5e
`define LMRC_VSTEP 14'h001e
// Timing counts in clock cycles
`define LMRC_OSC_DIV 16
`define LMRC_EXT_IDLE 64
// Status field positions
`define LMRC_ST_X 8
`define LMRC_ST_Y 16
`define LMRC_ST_ROW 26
// Config field positions
`define LMRC_CF_VOP 12
`endif

// [hdl/lmrc_pkg.sv]
// Purpose: Types of the LCD matrix RAM and command core
// Assumes: Nothing beyond the constants header
// Notes: Types only
package lmrc_pkg;
   typedef logic [6:0] lmrc_col_t;
   typedef logic [2:0] lmrc_bank_t;
   typedef logic [7:0] lmrc_byte_t;
   typedef enum logic {LMRC_BUS_IDLE, LMRC_BUS_ACK} lmrc_bus_t;
endpackage : lmrc_pkg

// [hdl/lmrc_core.sv]
// Purpose: Command decoder, settings, display RAM and row scan
// Assumes: Commands and data arrive as Avalon-MM writes
// Notes: One wait state on every bus access
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "lmrc_defs.svh"
module lmrc_core #(
   parameter int OSC_DIV = `LMRC_OSC_DIV,
   parameter int EXT_IDLE = `LMRC_EXT_IDLE
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_EXTERNAL_RESET_N,
   input wire logic I_POR_ENABLE_STRAP,
   input wire logic I_CLOCK_INPUT_PIN,
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   output logic [5:0] O_ROW_INDEX,
   output logic O_ROW_ACTIVE,
   output logic [127:0] O_COLUMN_DATA,
   output logic O_POWER_DOWN,
   output logic O_ICON_MODE,
   output logic [5:0] O_MUX_RATE,
   output logic [2:0] O_BIAS_N,
   output logic [3:0] O_BIAS_DIVISOR,
   output logic [2:0] O_TEMP_COEF_CODE,
   output logic O_HV_GENERATOR_ENABLE,
   output logic O_VOLTAGE_RANGE_SELECT,
   output logic [2:0] O_MULT_FACTOR,
   output logic [6:0] O_DRIVE_VOLTAGE_CODE,
   output logic [13:0] O_DRIVE_VOLTAGE_MV
);

   // ***********************************
   // Functions
   // ***********************************

   // Rows in one frame for the multiplex field
   function automatic logic [5:0] mux_rows(input logic [1:0] m);
      case (m)
         2'h2: mux_rows = 6'h1a;
         2'h1: mux_rows = 6'h22;
         default: mux_rows = 6'h11;
      endcase
   endfunction : mux_rows

   // Interlaced successor: evens from 0, then odds from 1
   function automatic logic [5:0] next_row(input logic [5:0] r,
         input logic [5:0] n, input logic icon);
      logic [6:0] r2;
      r2 = {1'b0, r} + 7'h02;
      if (icon) begin
         next_row = `LMRC_ICON_ROW;
      end else if (r2 < {1'b0, n}) begin
         next_row = r2[5:0];
      end else if (!r[0] && n > 6'h01) begin
         next_row = 6'h01;
      end else begin
         next_row = 6'h00;
      end
   endfunction : next_row

   // Target voltage in millivolts
   function automatic logic [13:0] drive_mv(input logic [6:0] c,
         input logic hi);
      logic [13:0] base;
      base = hi ? `LMRC_VOFS_HI : `LMRC_VOFS_LO;
      drive_mv = base + 14'({7'h00, c} * `LMRC_VSTEP);
   endfunction : drive_mv

   // ***********************************
   // Pin synchronisers and reset select
   // ***********************************

   logic rstn_s1_q, rstn_s2_q;
   logic strap_s1_q, strap_s2_q;
   logic osc_s1_q, osc_s2_q, osc_s3_q;
   logic core_rst;

   // Two flops on every pin before use
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rstn_s1_q <= 1'b1;
         rstn_s2_q <= 1'b1;
         strap_s1_q <= 1'b1;
         strap_s2_q <= 1'b1;
         osc_s1_q <= 1'b1;
         osc_s2_q <= 1'b1;
         osc_s3_q <= 1'b1;
      end else begin
         rstn_s1_q <= I_EXTERNAL_RESET_N;
         rstn_s2_q <= rstn_s1_q;
         strap_s1_q <= I_POR_ENABLE_STRAP;
         strap_s2_q <= strap_s1_q;
         osc_s1_q <= I_CLOCK_INPUT_PIN;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   // Pin reset only counts with power-on reset strapped off
   assign core_rst = I_RST | (~strap_s2_q & ~rstn_s2_q);

   // ***********************************
   // Register bus slave
   // ***********************************

   lmrc_pkg::lmrc_bus_t bus_q;
   logic bus_req, bus_go;
   logic cmd_stb, data_stb;
   logic [31:0] rdata_q;
   logic [31:0] stat_w, conf_w;

   assign bus_req = I_AVS_READ | I_AVS_WRITE;
   // One wait state on every access
   assign O_AVS_WAITREQUEST = bus_req & (bus_q == lmrc_pkg::LMRC_BUS_IDLE);
   assign bus_go = I_AVS_WRITE & (bus_q == lmrc_pkg::LMRC_BUS_ACK);
   // Only writes reach the core; reads send back only the status and config words
   assign cmd_stb = bus_go & I_AVS_BYTEENABLE[0]
      & (I_AVS_ADDRESS == `LMRC_OFF_CMD);
   assign data_stb = bus_go & I_AVS_BYTEENABLE[0]
      & (I_AVS_ADDRESS == `LMRC_OFF_DATA);
   assign O_AVS_READDATA = rdata_q;

   // Handshake state
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         bus_q <= lmrc_pkg::LMRC_BUS_IDLE;
      end else begin
         case (bus_q)
            lmrc_pkg::LMRC_BUS_IDLE: begin
               if (bus_req) begin
                  bus_q <= lmrc_pkg::LMRC_BUS_ACK;
               end
            end
            default: begin
               bus_q <= lmrc_pkg::LMRC_BUS_IDLE;
            end
         endcase
      end
   end

   // Read data latched in the wait cycle; unmapped reads give zero
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         rdata_q <= 32'h0;
      end else if (I_AVS_READ && bus_q == lmrc_pkg::LMRC_BUS_IDLE) begin
         if (I_AVS_ADDRESS == `LMRC_OFF_STAT) begin
            rdata_q <= stat_w;
         end else if (I_AVS_ADDRESS == `LMRC_OFF_CONF) begin
            rdata_q <= conf_w;
         end else begin
            rdata_q <= 32'h0;
         end
      end
   end

   // ***********************************
   // Command decoder and settings
   // ***********************************

   logic [7:0] ir_q; // instruction_holding_reg
   logic [7:0] dr_q; // data_holding_reg
   logic [1:0] page_q;
   logic power_down_flag_q, vert_q;
   logic disp_d_q, disp_e_q, icon_only_select_q;
   logic [1:0] mux_q, mult_q;
   logic [2:0] bias_code_q, temp_coef_code_q;
   logic hv_generator_enable_q, voltage_range_select_q;
   logic [6:0] drive_voltage_code_q;
   lmrc_pkg::lmrc_col_t x_q, x_d;
   lmrc_pkg::lmrc_bank_t y_q, y_d;
   logic [7:0] c;

   assign c = I_AVS_WRITEDATA[7:0];

   // Holding registers keep the last command and data byte
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         ir_q <= `LMRC_RST_CODE;
         dr_q <= `LMRC_RST_CODE;
      end else if (cmd_stb) begin
         ir_q <= c;
      end else if (data_stb) begin
         dr_q <= c;
      end
   end

   // Setting decode; still runs during power-down
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         page_q <= `LMRC_PAGE_FUNC;
         power_down_flag_q <= `LMRC_RST_PD;
         vert_q <= `LMRC_RST_V;
         disp_d_q <= 1'b0;
         disp_e_q <= 1'b0;
         icon_only_select_q <= 1'b0;
         mux_q <= 2'h0;
         bias_code_q <= 3'h0;
         temp_coef_code_q <= 3'h0;
         hv_generator_enable_q <= 1'b0;
         voltage_range_select_q <= 1'b0;
         mult_q <= 2'h0;
         drive_voltage_code_q <= 7'h00;
      end else if (cmd_stb) begin
         if (c == 8'h01) begin
            page_q <= `LMRC_PAGE_FUNC;
         end else if (page_q == `LMRC_PAGE_FUNC) begin
            if (c[7:2] == 6'h02) begin
               page_q <= c[1:0];
            end else if (c[7:3] == 5'h04) begin
               power_down_flag_q <= c[2];
               vert_q <= c[1];
            end
         end else if (page_q == `LMRC_PAGE_DISP) begin
            if (c[7:2] == 6'h01) begin
               mux_q <= c[1:0];
            end else if (c[7:3] == 5'h01) begin
               disp_d_q <= c[2];
               icon_only_select_q <= c[1];
               disp_e_q <= c[0];
            end else if (c[7:3] == 5'h02) begin
               bias_code_q <= c[2:0];
            end
         end else if (page_q == `LMRC_PAGE_HV) begin
            if (c[7]) begin
               drive_voltage_code_q <= c[6:0];
            end else if (c[7:2] == 6'h01) begin
               voltage_range_select_q <= c[1];
               hv_generator_enable_q <= c[0];
            end else if (c[7:2] == 6'h02) begin
               mult_q <= c[1:0];
            end else if (c[7:3] == 5'h04) begin
               temp_coef_code_q <= c[2:0];
            end
         end
      end
   end

   // ***********************************
   // Address pointer
   // ***********************************

   // Next pointer after a data byte
   always_comb begin
      x_d = x_q;
      y_d = y_q;
      if (y_q == `LMRC_ICON_Y) begin
         x_d = x_q + 7'h01;
      end else if (vert_q) begin
         if (y_q == `LMRC_LAST_Y) begin
            y_d = 3'h0;
            x_d = x_q + 7'h01;
         end else begin
            y_d = y_q + 3'h1;
         end
      end else if (x_q == `LMRC_LAST_X) begin
         x_d = 7'h00;
         y_d = (y_q == `LMRC_LAST_Y) ? 3'h0 : y_q + 3'h1;
      end else begin
         x_d = x_q + 7'h01;
      end
   end

   logic bank_bad;
   // Codes 6 and 7 name no bank
   assign bank_bad = (y_q > `LMRC_ICON_Y);

   // Pointer set by command, stepped by data
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         x_q <= 7'h00;
         y_q <= 3'h0;
      end else if (cmd_stb && page_q == `LMRC_PAGE_FUNC) begin
         if (c[7]) begin
            x_q <= c[6:0];
         end else if (c[7:3] == 5'h08) begin
            y_q <= c[2:0];
         end
      end else if (data_stb && !bank_bad) begin
         x_q <= x_d;
         y_q <= y_d;
      end
   end

   // ***********************************
   // Display RAM
   // ***********************************

   // Contents are not reset; they are undefined after reset
   logic [7:0] ram_q [0:`LMRC_BANKS-1][0:`LMRC_COLS-1];
   logic [7:0] wmask;

   // Bank 4 holds one row, icon bank holds one row
   always_comb begin
      if (y_q == `LMRC_LAST_Y) begin
         wmask = {7'h00, c[0]};
      end else if (y_q == `LMRC_ICON_Y) begin
         wmask = {3'h0, c[4], 4'h0};
      end else begin
         wmask = c;
      end
   end

   // Byte written at column x of bank y
   always_ff @(posedge I_CLK) begin
      if (data_stb && !bank_bad && !core_rst) begin
         ram_q[y_q][x_q] <= wmask;
      end
   end

   // ***********************************
   // Display timing
   // ***********************************

   logic [15:0] div_q;
   logic [15:0] act_q;
   logic osc_edge, tick;
   logic [5:0] row_q, row_nx;

   assign osc_edge = osc_s2_q & ~osc_s3_q;
   assign tick = ~power_down_flag_q & ((act_q != 16'h0) ? osc_edge
      : (div_q == 16'(OSC_DIV - 1)));

   // Pin counts as a clock while edges keep arriving
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         act_q <= 16'h0;
      end else if (osc_edge) begin
         act_q <= 16'(EXT_IDLE);
      end else if (act_q != 16'h0) begin
         act_q <= act_q - 16'h1;
      end
   end

   // Internal oscillator halted in power-down to save power
   always_ff @(posedge I_CLK) begin
      if (core_rst || power_down_flag_q) begin
         div_q <= 16'h0;
      end else if (div_q == 16'(OSC_DIV - 1)) begin
         div_q <= 16'h0;
      end else begin
         div_q <= div_q + 16'h1;
      end
   end

   assign row_nx = next_row(row_q, mux_rows(mux_q),
      icon_only_select_q);

   // Row bits of the next row for all columns
   logic [127:0] row_bits;
   logic [2:0] rb_bank, rb_bit;
   always_comb begin
      rb_bank = {1'b0, row_nx[4:3]};
      rb_bit = row_nx[2:0];
      if (row_nx == 6'h20) begin
         rb_bank = `LMRC_LAST_Y;
         rb_bit = 3'h0;
      end else if (row_nx == `LMRC_ICON_ROW) begin
         rb_bank = `LMRC_ICON_Y;
         rb_bit = 3'h4;
      end
      for (int k = 0; k < `LMRC_COLS; k++) begin
         row_bits[k] = ram_q[rb_bank][k][rb_bit];
      end
   end

   // Row and column drive; all off in reset and power-down
   always_ff @(posedge I_CLK) begin
      if (core_rst || power_down_flag_q) begin
         // Odd park value, so the first tick lands on row 0
         row_q <= 6'h3f;
         O_ROW_INDEX <= 6'h00;
         O_ROW_ACTIVE <= 1'b0;
         O_COLUMN_DATA <= 128'h0;
      end else if (tick) begin
         row_q <= row_nx;
         O_ROW_INDEX <= row_nx;
         O_ROW_ACTIVE <= 1'b1;
         case ({disp_d_q, disp_e_q})
            2'h2: O_COLUMN_DATA <= row_bits;
            2'h1: O_COLUMN_DATA <= {128{1'b1}};
            2'h3: O_COLUMN_DATA <= ~row_bits;
            default: O_COLUMN_DATA <= 128'h0;
         endcase
      end
   end


   // ***********************************
   // Analog settings and status words
   // ***********************************

   // Registered so analog controls never glitch
   always_ff @(posedge I_CLK) begin
      if (core_rst) begin
         O_POWER_DOWN <= `LMRC_RST_PD;
         O_ICON_MODE <= 1'b0;
         O_MUX_RATE <= 6'h11;
         O_BIAS_N <= 3'h7;
         O_BIAS_DIVISOR <= 4'hb;
         O_TEMP_COEF_CODE <= 3'h0;
         O_HV_GENERATOR_ENABLE <= 1'b0;
         O_VOLTAGE_RANGE_SELECT <= 1'b0;
         O_MULT_FACTOR <= 3'h2;
         O_DRIVE_VOLTAGE_CODE <= 7'h00;
         O_DRIVE_VOLTAGE_MV <= `LMRC_VOFS_LO;
      end else begin
         O_POWER_DOWN <= power_down_flag_q;
         O_ICON_MODE <= icon_only_select_q;
         O_MUX_RATE <= mux_rows(mux_q);
         O_BIAS_N <= ~bias_code_q;
         O_BIAS_DIVISOR <= {1'b0, ~bias_code_q} + 4'h4;
         O_TEMP_COEF_CODE <= temp_coef_code_q;
         O_HV_GENERATOR_ENABLE <= hv_generator_enable_q;
         O_VOLTAGE_RANGE_SELECT <= voltage_range_select_q;
         O_MULT_FACTOR <= {1'b0, mult_q} + 3'h2;
         O_DRIVE_VOLTAGE_CODE <= drive_voltage_code_q;
         O_DRIVE_VOLTAGE_MV <= drive_mv(drive_voltage_code_q,
            voltage_range_select_q);
      end
   end

   // Status word
   always_comb begin
      stat_w = 32'h0;
      stat_w[1:0] = page_q;
      stat_w[2] = power_down_flag_q;
      stat_w[3] = vert_q;
      stat_w[4] = disp_e_q;
      stat_w[5] = disp_d_q;
      stat_w[6] = icon_only_select_q;
      stat_w[7] = bank_bad;
      stat_w[`LMRC_ST_X +: 7] = x_q;
      stat_w[`LMRC_ST_Y +: 3] = y_q;
      stat_w[24] = (act_q != 16'h0);
      stat_w[25] = O_ROW_ACTIVE;
      stat_w[`LMRC_ST_ROW +: 6] = row_q;
   end

   // Configuration word
   always_comb begin
      conf_w = 32'h0;
      conf_w[1:0] = mux_q;
      conf_w[4:2] = bias_code_q;
      conf_w[7:5] = temp_coef_code_q;
      conf_w[8] = hv_generator_enable_q;
      conf_w[9] = voltage_range_select_q;
      conf_w[11:10] = mult_q;
      conf_w[`LMRC_CF_VOP +: 7] = drive_voltage_code_q;
      conf_w[20 +: 8] = ir_q;
   end

endmodule : lmrc_core

// [testbench/lmrc_osc_model.sv]
// Purpose: External clock source for the oscillator pin
// Assumes: Enabled only while the bench wants external display timing
// Notes: Pin parks high when off, like an input tied to the supply
`timescale 1ns/100ps
module lmrc_osc_model #(
   parameter int HALF_NS = 40
) (
   input wire logic i_en,
   output logic o_pin
);
   // Toggles while enabled; once disabled it returns high, which can give the core one last rising edge
   initial begin
      o_pin = 1'b1;
      forever begin
         #(HALF_NS);
         o_pin = i_en ? ~o_pin : 1'b1;
      end
   end
endmodule : lmrc_osc_model

// [testbench/lmrc_core_checker.sv]
// Purpose: Concurrent checks on the core's ports
// Assumes: Mux rate and icon mode change only while powered down
// Notes: Disabled while the power-on reset is high
`timescale 1ns/100ps
module lmrc_core_checker (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic O_AVS_WAITREQUEST,
   input wire logic [5:0] O_ROW_INDEX,
   input wire logic O_ROW_ACTIVE,
   input wire logic [127:0] O_COLUMN_DATA,
   input wire logic O_POWER_DOWN,
   input wire logic O_ICON_MODE,
   input wire logic [5:0] O_MUX_RATE,
   input wire logic [2:0] O_BIAS_N,
   input wire logic [3:0] O_BIAS_DIVISOR,
   input wire logic O_VOLTAGE_RANGE_SELECT,
   input wire logic [6:0] O_DRIVE_VOLTAGE_CODE,
   input wire logic [13:0] O_DRIVE_VOLTAGE_MV
);
   logic req;
   logic [5:0] prev_q;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   // Any bus request
   assign req = I_AVS_READ | I_AVS_WRITE;
   // Row shown one cycle earlier, for the scan order
   always_ff @(posedge I_CLK) begin
      prev_q <= O_ROW_INDEX;
   end
   a_wait_first: assert property ($rose(req) |-> O_AVS_WAITREQUEST)
      else $error("request not held off in its first cycle");
   a_wait_one: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("bus wait longer than one cycle");
   a_reset_dark: assert property ($fell(I_RST) |-> O_POWER_DOWN && !O_ROW_ACTIVE
      && O_COLUMN_DATA == '0 && O_BIAS_N == 3'h7 && O_MUX_RATE == 6'h11)
      else $error("state after reset wrong");
   a_pd_dark: assert property (O_POWER_DOWN [*2] |-> !O_ROW_ACTIVE && O_COLUMN_DATA == '0)
      else $error("outputs driven in power-down");
   a_pd_exit: assert property ($fell(O_POWER_DOWN) |-> ##[1:40] O_ROW_ACTIVE)
      else $error("scan did not start after power-down");
   a_row_first: assert property ($rose(O_ROW_ACTIVE) |-> O_ROW_INDEX == 6'h00 || O_ICON_MODE)
      else $error("scan did not start at row zero");
   a_row_order: assert property (O_ROW_ACTIVE && $past(O_ROW_ACTIVE) && !O_ICON_MODE
      && O_ROW_INDEX != prev_q |-> O_ROW_INDEX == (prev_q + 6'h02 < O_MUX_RATE ?
      prev_q + 6'h02 : {5'h00, ~prev_q[0]}))
      else $error("rows out of interlaced order");
   a_icon_row: assert property (O_ICON_MODE && O_ROW_ACTIVE && $changed(O_ROW_INDEX)
      |-> O_ROW_INDEX == 6'h21)
      else $error("icon mode drove a matrix row");
   a_bias_map: assert property (O_BIAS_DIVISOR == {1'b0, O_BIAS_N} + 4'h4)
      else $error("bias divisor not n plus four");
   a_volt_map: assert property (O_DRIVE_VOLTAGE_MV == (O_VOLTAGE_RANGE_SELECT ? 14'h1a5e
      : 14'h0b7c) + 14'h001e * {7'h00, O_DRIVE_VOLTAGE_CODE})
      else $error("drive voltage not offset plus steps");
   a_mux_legal: assert property (O_MUX_RATE inside {6'h11, 6'h1a, 6'h22})
      else $error("illegal multiplex rate");
endmodule : lmrc_core_checker
bind lmrc_core lmrc_core_checker u_chk (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_ROW_INDEX(O_ROW_INDEX),
   .O_ROW_ACTIVE(O_ROW_ACTIVE), .O_COLUMN_DATA(O_COLUMN_DATA), .O_POWER_DOWN(O_POWER_DOWN),
   .O_ICON_MODE(O_ICON_MODE), .O_MUX_RATE(O_MUX_RATE), .O_BIAS_N(O_BIAS_N),
   .O_BIAS_DIVISOR(O_BIAS_DIVISOR), .O_VOLTAGE_RANGE_SELECT(O_VOLTAGE_RANGE_SELECT),
   .O_DRIVE_VOLTAGE_CODE(O_DRIVE_VOLTAGE_CODE), .O_DRIVE_VOLTAGE_MV(O_DRIVE_VOLTAGE_MV)
);

// [testbench/testbench.sv]
// Purpose: Self-checking bench of the LCD matrix RAM and command core
// Assumes: Short scan counts, pin clock from the oscillator model
// Notes: Reads queue their expectations for the watching process
`timescale 1ns/100ps
`include "lmrc_defs.svh"
module testbench;
   logic clk, rst, ext_n, strap, osc_en, pin, rd_s, wr_s, wait_s, row_act, pd, icon, hv_generator_enable, voltage_range_select;
   logic [3:0] addr, be, bias_div;
   logic [31:0] wdata, rdata;
   logic [5:0] row_idx, mux;
   logic [127:0] cols;
   logic [2:0] bias_n, tc, mult;
   logic [6:0] vcode;
   logic [13:0] vmv;
   logic [7:0] b, c, e;
   logic [63:0] cur;
   logic [63:0] exp_q[$];
   logic [7:0] mc[4] = '{8'h07, 8'h04, 8'h06, 8'h05};
   logic [5:0] mr[4] = '{6'h11, 6'h11, 6'h1a, 6'h22};
   logic [7:0] dm[4] = '{8'h08, 8'h0c, 8'h09, 8'h0d};
   logic [7:0] fc[7] = '{8'h24, 8'h24, 8'h26, 8'h26, 8'h26, 8'h26, 8'h26};
   logic [7:0] yc[7] = '{8'h40, 8'h44, 8'h43, 8'h43, 8'h44, 8'h45, 8'h46};
   logic [7:0] xc[7] = '{8'hfe, 8'hff, 8'h85, 8'h85, 8'hff, 8'hff, 8'h80};
   int nd[7] = '{2, 1, 1, 2, 1, 1, 1};
   logic [31:0] ea[7] = '{32'h0001_0000, 32'h0, 32'h0004_0500, 32'h0000_0600, 32'h0,
      32'h0005_0000, 32'h0006_0080};
   int bad_count = 0;
   int num_checks = 0;
   int k, j;
   lmrc_core #(.OSC_DIV(4), .EXT_IDLE(16)) dut (
      .I_CLK(clk), .I_RST(rst), .I_EXTERNAL_RESET_N(ext_n), .I_POR_ENABLE_STRAP(strap),
      .I_CLOCK_INPUT_PIN(pin), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_s), .I_AVS_WRITE(wr_s),
      .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(wait_s), .O_ROW_INDEX(row_idx), .O_ROW_ACTIVE(row_act),
      .O_COLUMN_DATA(cols), .O_POWER_DOWN(pd), .O_ICON_MODE(icon), .O_MUX_RATE(mux),
      .O_BIAS_N(bias_n), .O_BIAS_DIVISOR(bias_div), .O_TEMP_COEF_CODE(tc),
      .O_HV_GENERATOR_ENABLE(hv_generator_enable), .O_VOLTAGE_RANGE_SELECT(voltage_range_select), .O_MULT_FACTOR(mult),
      .O_DRIVE_VOLTAGE_CODE(vcode), .O_DRIVE_VOLTAGE_MV(vmv)
   );
   lmrc_osc_model u_osc (.i_en(osc_en), .o_pin(pin));
   // Bench clock, 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Masked compare, counts every call
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      num_checks++;
      if ((got & msk) !== (exp & msk)) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got & msk, exp & msk);
      end
   endtask : cmp
   task automatic print_verdict();
      if (exp_q.size() != 0) begin
         bad_count++;
         $display("wrong value at %0t: reads left unchecked", $time);
      end
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   task automatic hang();
      bad_count++;
      $display("wrong value at %0t: wait ran out", $time);
      print_verdict();
   endtask : hang
   // One bus access; waitrequest is sampled mid-cycle where it has settled
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      logic ws;
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr_s <= w;
      rd_s <= ~w;
      for (n = 0; n < 20; n++) begin
         @(negedge clk);
         ws = wait_s;
         @(posedge clk);
         if (ws === 1'b0) break;
      end
      if (n == 20) hang();
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask : bus
   task automatic cmd(input logic [7:0] d);
      bus(`LMRC_OFF_CMD, 1'b1, d);
   endtask : cmd
   task automatic dat(input logic [7:0] d);
      bus(`LMRC_OFF_DATA, 1'b1, d);
   endtask : dat
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
      exp_q.push_back({msk, exp});
      bus(a, 1'b0, 8'h00);
   endtask : rd
   // Waits for row r to be driven, then checks one column
   task automatic see_row(input logic [5:0] r, input int col, input logic v);
      int n;
      repeat (10) @(negedge clk);
      for (n = 0; n < 600; n++) begin
         @(negedge clk);
         if (row_act === 1'b1 && row_idx === r) break;
      end
      if (n == 600) hang();
      cmp({31'h0, cols[col]}, {31'h0, v}, 32'h1);
   endtask : see_row
   // Read watcher: oldest note against the data of the finishing read
   always @(negedge clk) begin
      if (rd_s === 1'b1 && wait_s === 1'b0 && exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         cmp(rdata, cur[31:0], cur[63:32]);
      end
   end
   // Main sequence; RAM writes and all settings but the display mode go in while powered down
   initial begin
      rst = 1'b1;
      ext_n = 1'b1;
      strap = 1'b1;
      osc_en = 1'b0;
      addr = 4'h0;
      rd_s = 1'b0;
      wr_s = 1'b0;
      wdata = 32'h0;
      be = 4'h1;
      k = $urandom(46);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(`LMRC_OFF_STAT, 32'h4, 32'h0007_7fff);
      rd(`LMRC_OFF_CONF, 32'h0, 32'h0ff7_ffff);
      rd(4'h1, 32'h0, 32'hffff_ffff);
      @(negedge clk);
      cmp({2'h0, bias_n, bias_div, mux, mult, vmv}, {2'h0, 3'h7, 4'hb, 6'h11, 3'h2, 14'h0b7c}, '1);
      $display("test reset done");
      cmd(8'h09);
      for (k = 0; k < 4; k++) begin
         cmd(mc[k]);
         repeat (2) @(negedge clk);
         cmp({26'h0, mux}, {26'h0, mr[k]}, '1);
      end
      for (k = 0; k < 8; k++) begin
         cmd(8'h10 | 8'(k));
         repeat (2) @(negedge clk);
         cmp({29'h0, bias_n}, {29'h0, ~3'(k)}, 32'h7);
      end
      b = 8'($urandom);
      cmd(8'h01);
      cmd(8'h0a);
      cmd(8'h07);
      cmd(8'h0b);
      cmd(8'h25);
      cmd(8'h1f);
      cmd(8'h80 | b);
      rd(`LMRC_OFF_CONF, {13'h0, b[6:0], 12'hfbd}, 32'h0007_ffff);
      @(negedge clk);
      cmp({24'h0, tc, hv_generator_enable, voltage_range_select, mult}, {24'h0, 3'h5, 2'h3, 3'h5}, '1);
      cmp({18'h0, vmv}, {18'h0, 14'h1a5e + 14'h001e * {7'h0, b[6:0]}}, '1);
      cmd(8'h05);
      repeat (2) @(negedge clk);
      cmp({18'h0, vmv}, {18'h0, 14'h0b7c + 14'h001e * {7'h0, b[6:0]}}, '1);
      $display("test settings done");
      cmd(8'h01);
      for (k = 0; k < 7; k++) begin
         cmd(fc[k]);
         cmd(yc[k]);
         cmd(xc[k]);
         repeat (nd[k]) dat(8'($urandom));
         rd(`LMRC_OFF_STAT, ea[k], 32'h0007_7f80);
      end
      $display("test addressing done");
      b = 8'($urandom);
      c = 8'($urandom);
      e = 8'($urandom);
      k = $urandom_range(7, 0);
      cmd(8'h09);
      cmd(8'h0c);
      cmd(8'h01);
      cmd(8'h24);
      cmd(8'h40);
      cmd(8'h89);
      dat(b);
      cmd(8'h44);
      cmd(8'h82);
      dat(c);
      cmd(8'h45);
      cmd(8'h87);
      dat(e);
      cmd(8'h20);
      see_row(6'(k), 9, b[k]);
      see_row(6'h20, 2, c[0]);
      see_row(6'h21, 7, e[4]);
      cmd(8'h09);
      for (j = 0; j < 4; j++) begin
         cmd(dm[j]);
         see_row(6'(k), 9, dm[j][2] ? b[k] ^ dm[j][0] : dm[j][0]);
      end
      $display("test scan done");
      osc_en <= 1'b1;
      repeat (30) @(posedge clk);
      rd(`LMRC_OFF_STAT, 32'h0100_0000, 32'h0100_0000);
      see_row(6'(k), 9, ~b[k]);
      osc_en <= 1'b0;
      $display("test pin clock done");
      cmd(8'h01);
      cmd(8'h24);
      repeat (3) @(negedge clk);
      cmp({30'h0, pd, row_act}, 32'h2, 32'h3);
      cmd(8'h09);
      cmd(8'h0e);
      cmd(8'h01);
      cmd(8'h20);
      see_row(6'h21, 7, e[4]);
      $display("test icon mode done");
      ext_n <= 1'b0;
      repeat (6) @(posedge clk);
      ext_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`LMRC_OFF_STAT, 32'h40, 32'h44);
      strap <= 1'b0;
      repeat (3) @(posedge clk);
      ext_n <= 1'b0;
      repeat (6) @(posedge clk);
      ext_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`LMRC_OFF_STAT, 32'h4, 32'h0007_7fff);
      strap <= 1'b1;
      cmd(8'h20);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      be <= 4'h0;
      cmd(8'h0a);
      be <= 4'h1;
      rd(`LMRC_OFF_STAT, 32'h4, 32'h7);
      $display("test resets done");
      print_verdict();
   end
endmodule : testbench
